// *** rtl/pmx_frame_engine.sv ***
`timescale 1ns/100ps
`include "pmx_regs.svh"
module pmx_frame_engine
    import pmx_pkg::*;
#(
    parameter int unsigned LINK_KHZ = `PMX_LINK_KHZ
)(
    input wire logic mgmt_clk, // link clock
    input wire logic rst_b,    // async reset, active low
    pmx_mgmt_if.eng  bus       // command and pin side
);
    localparam int unsigned HALF_RAW =
        (LINK_KHZ + 2 * `PMX_MDC_FREQ_KHZ - 1) / (2 * `PMX_MDC_FREQ_KHZ);
    localparam int unsigned HALF_CYC = (HALF_RAW < 1) ? 1 : HALF_RAW;

    pmx_eng_state_t state_reg;
    logic [2:0]     start_sync_reg;
    logic [1:0]     mdi_sync_reg;
    logic [15:0]    div_reg;
    logic [6:0]     bit_reg;
    logic [63:0]    shift_reg;
    logic           mdc_reg;
    logic           oe_b_reg;
    logic [15:0]    rdata_reg;
    logic           done_tgl_reg;
    logic           start_edge;
    logic           tick;

    // command toggle and pin data enter this domain through two flops
    always_ff @(posedge mgmt_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            start_sync_reg <= 3'h0;
            mdi_sync_reg   <= 2'h3;
        end
        else
        begin
            start_sync_reg <= {start_sync_reg[1:0], bus.start_tgl};
            mdi_sync_reg   <= {mdi_sync_reg[0], bus.mdi};
        end
    end

    assign start_edge = start_sync_reg[2] ^ start_sync_reg[1];
    assign tick       = (div_reg == 16'(HALF_CYC - 1));

    // frame sequencing: low half drives a bit, high half lets it be sampled
    always_ff @(posedge mgmt_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= PMX_ENG_IDLE;
            div_reg   <= 16'h0000;
            bit_reg   <= 7'h00;
            mdc_reg   <= 1'b0;
            oe_b_reg  <= 1'b1;
            shift_reg <= 64'h0;
        end
        else if (state_reg == PMX_ENG_IDLE)
        begin
            if (start_edge)
            begin
                state_reg <= PMX_ENG_RUN;                           // R1
                div_reg   <= 16'h0000;
                bit_reg   <= 7'h00;
                mdc_reg   <= 1'b0;
                oe_b_reg  <= 1'b0;
                shift_reg <= {32'hffff_ffff, 2'b01,                 // R20
                              bus.wr ? 2'b01 : 2'b10, bus.phy_sel,  // R2 R4 R5
                              bus.reg_idx, bus.wr ? 2'b10 : 2'b00,  // R3 R21
                              bus.wr ? bus.wdata : 16'h0000};       // R4
            end
        end
        else
        begin
            div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
            if (tick)
            begin
                mdc_reg <= ~mdc_reg;
                if (mdc_reg && bit_reg == `PMX_FRAME_LAST)
                begin
                    state_reg <= PMX_ENG_IDLE;
                    oe_b_reg  <= 1'b1;                               // idle: line released
                end
                else if (mdc_reg)
                begin
                    bit_reg   <= bit_reg + 7'h01;
                    shift_reg <= {shift_reg[62:0], 1'b0};            // R20
                    oe_b_reg  <= !bus.wr && (bit_reg + 7'h01 >= `PMX_TA_BIT);
                end
            end
        end
    end

    // read data shifted in at each rising mdc edge of a read's data bits
    always_ff @(posedge mgmt_clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata_reg <= `PMX_RST_DATA;
        else if (state_reg == PMX_ENG_RUN && tick && !mdc_reg && !bus.wr
                 && bit_reg >= `PMX_DATA_BIT)
            rdata_reg <= {rdata_reg[14:0], mdi_sync_reg[1]};         // R5
    end

    // completion told after the last bit's high half
    always_ff @(posedge mgmt_clk or negedge rst_b)
    begin
        if (!rst_b)
            done_tgl_reg <= 1'b0;
        else if (state_reg == PMX_ENG_RUN && tick && mdc_reg && bit_reg == `PMX_FRAME_LAST)
            done_tgl_reg <= ~done_tgl_reg;                           // R23
    end

    assign bus.mdc      = mdc_reg;
    assign bus.mdo      = shift_reg[63];
    assign bus.mdo_oe_b = oe_b_reg;
    assign bus.rdata    = rdata_reg;
    assign bus.done_tgl = done_tgl_reg;

    sequence s_launch;
        $rose(state_reg == PMX_ENG_RUN);
    endsequence
    a_frame_min_len: assert property (@(posedge mgmt_clk) disable iff (!rst_b)
        s_launch |-> (state_reg == PMX_ENG_RUN)[*8])                 // R20
        else $error("frame ended too early");
    a_write_ta: assert property (@(posedge mgmt_clk) disable iff (!rst_b)
        state_reg == PMX_ENG_RUN && bus.wr && bit_reg == `PMX_TA_BIT
        |-> shift_reg[63] && !oe_b_reg)                              // R21
        else $error("write turnaround first bit not one");
    a_read_release: assert property (@(posedge mgmt_clk) disable iff (!rst_b)
        state_reg == PMX_ENG_RUN && !bus.wr && bit_reg > `PMX_TA_BIT |-> oe_b_reg) // R14
        else $error("data line driven during read reply");
endmodule

// *** rtl/pmx_mgmt_if.sv ***
`timescale 1ns/100ps
interface pmx_mgmt_if;
    logic        start_tgl;
    logic        wr;
    logic [4:0]  phy_sel;
    logic [4:0]  reg_idx;
    logic [15:0] wdata;
    logic        mdi;
    logic        done_tgl;
    logic [15:0] rdata;
    logic        mdc;
    logic        mdo;
    logic        mdo_oe_b;
    modport ctrl (output start_tgl, wr, phy_sel, reg_idx, wdata, mdi,
                  input done_tgl, rdata, mdc, mdo, mdo_oe_b);
    modport eng  (input start_tgl, wr, phy_sel, reg_idx, wdata, mdi,
                  output done_tgl, rdata, mdc, mdo, mdo_oe_b);
endinterface

// *** rtl/pmx_phy_mgmt_mux.sv ***
// Overview of operation
// [R1] command register write starts a management frame
// [R2] bits 15:11 pick target PHY, reset zero
// [R3] bits 10:6 pick PHY register, reset zero
// [R4] direction one sends data register to PHY
// [R5] direction zero stores returned data in register
// [R6] busy sets on command write, holds meanwhile
// [R7] busy read-only, clears when transaction finishes
// [R8] masters wait for busy zero before writing
// [R9] masters keep write data until busy clears
// [R10] read data valid only after busy clears
// [R11] loader polls busy before further writes
// [R12] loader only writes, so issues writes
// [R13] mode picks one master for all slaves; the serial slave stays on the port 0 pins in every mode
// [R14] mux steers read data and pin enables
// [R15] port 0 offers six management path modes
// [R16] MAC serial mode: external master reaches all
// [R17] MAC serial mode: registers reachable from both
// [R18] initialization: engine drives both internal PHYs
// [R19] initialization: only loader reaches the registers
// [R20] frames at 2.5 MHz, MSB first
// [R21] write turnaround driven one then zero
// [R22] data read gives last written when writing
// [R23] busy clears after last bit and storage
`timescale 1ns/100ps
`include "pmx_regs.svh"
module pmx_phy_mgmt_mux
    import pmx_pkg::*;
#(
    parameter int unsigned LINK_KHZ = `PMX_LINK_KHZ
)(
    input  wire logic        clock,         // system clock, 25 MHz
    input  wire logic        rst_b,         // async reset, active low
    input  wire logic        mgmt_clk,      // link clock of the frame engine
    input  wire pmx_mode_t   port0_mode,    // port 0 management mode
    input  wire logic        host_wr_en,    // serial slave register write strobe
    input  wire logic        host_rd_en,    // serial slave register read strobe
    input  wire logic [7:0]  host_addr,     // serial slave register offset
    input  wire logic [31:0] host_wdata,    // serial slave write data
    output logic      [31:0] host_rdata,    // read data, one cycle after strobe
    input  wire logic        ee_wr_en,      // loader register write strobe
    input  wire logic [7:0]  ee_addr,       // loader register offset
    input  wire logic [31:0] ee_wdata,      // loader write data
    output logic             cmd_busy,      // busy flag for the loader's poll
    input  wire logic        p0_mdc_i,      // port 0 pin clock from external master
    input  wire logic        p0_mdio_i,     // port 0 pin data in
    output logic             p0_mdio_o,     // port 0 pin data out
    output logic             p0_mdio_oe_b,  // port 0 pin enable, low drives
    output logic             phy_mdc,       // clock to internal PHYs A and B
    output logic             phy_mdio,      // data to internal PHYs A and B
    input  wire logic        phya_mdo,      // PHY A data out
    input  wire logic        phya_mdo_oe_b, // PHY A drive enable, low drives
    input  wire logic        phyb_mdo,      // PHY B data out
    input  wire logic        phyb_mdo_oe_b, // PHY B drive enable, low drives
    output logic             sms_mdc,       // clock to serial management slave
    output logic             sms_mdio,      // data to serial management slave
    input  wire logic        sms_mdo,       // serial slave data out
    input  wire logic        sms_mdo_oe_b   // serial slave enable, low drives
);

    pmx_mgmt_if u_if ();

    logic [4:0]  phy_sel_reg;
    logic [4:0]  reg_idx_reg;
    logic        dir_write_reg;
    logic        busy_reg;
    logic [15:0] data_reg;
    logic [15:0] rd_result_reg;
    logic        start_tgl_reg;
    logic [2:0]  done_sync_reg;
    logic [1:0]  p0_mdc_sync_reg;
    logic [1:0]  p0_mdio_sync_reg;
    logic        init_phase;
    logic        host_ok;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic        cmd_wr;
    logic        data_wr;
    logic        launch;
    logic        done_pulse;
    logic        phy_rd;
    logic        sms_rd;

    ////////////////////////////////////////////////////////////////////////
    // register master selection

    // initialization modes keep the serial slave off the registers
    always_comb
    begin
        case (port0_mode)                                    // R15
            PMX_MAC_SMI_INIT,
            PMX_PHY_SMI_INIT: init_phase = 1'b1;             // R19
            default:          init_phase = 1'b0;             // R17
        endcase
    end

    assign host_ok = !init_phase;

    // the loader wins a same-cycle collision; it has no read path
    assign wr_en   = ee_wr_en || (host_ok && host_wr_en);    // R12
    assign wr_addr = ee_wr_en ? ee_addr : host_addr;
    assign wr_data = ee_wr_en ? ee_wdata : host_wdata;
    assign cmd_wr  = wr_en && (wr_addr == `PMX_OFF_CMD);
    assign data_wr = wr_en && (wr_addr == `PMX_OFF_DATA);

    // a command written while busy is dropped, the frame in flight is kept
    assign launch  = cmd_wr && !busy_reg;                    // R1

    ////////////////////////////////////////////////////////////////////////
    // command register

    // target, index and direction latched as the frame starts
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            phy_sel_reg   <= `PMX_RST_ADDR;
            reg_idx_reg   <= `PMX_RST_IDX;
            dir_write_reg <= 1'b0;
        end
        else if (launch)
        begin
            phy_sel_reg   <= wr_data[`PMX_CMD_ADDR_HI:`PMX_CMD_ADDR_LO]; // R2
            reg_idx_reg   <= wr_data[`PMX_CMD_IDX_HI:`PMX_CMD_IDX_LO];   // R3
            dir_write_reg <= wr_data[`PMX_CMD_DIR];                      // R4
        end
    end

    // busy: set by the command write, cleared by the engine's completion
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            busy_reg <= 1'b0;
        else if (launch)
            busy_reg <= 1'b1;                                // R6
        else if (done_pulse)
            busy_reg <= 1'b0;                                // R7
    end

    assign cmd_busy = busy_reg;                              // R11

    ////////////////////////////////////////////////////////////////////////
    // data register

    // master-written value, sent on writes and read back while writing
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            data_reg <= `PMX_RST_DATA;
        else if (data_wr)
            data_reg <= wr_data[15:0];                       // R22
    end

    // read results land in the same cycle that busy drops
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            rd_result_reg <= `PMX_RST_DATA;
        else if (done_pulse && !dir_write_reg)
            rd_result_reg <= u_if.rdata;                     // R5 R23
    end

    ////////////////////////////////////////////////////////////////////////
    // register read port

    // unmapped offsets and reads during initialization return zero
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            host_rdata <= 32'h0000_0000;
        else if (host_rd_en && host_ok)
        begin
            case (host_addr)
                `PMX_OFF_DATA: host_rdata <= {16'h0000,
                                              dir_write_reg ? data_reg : rd_result_reg}; // R10 R22
                `PMX_OFF_CMD:  host_rdata <= {16'h0000, phy_sel_reg, reg_idx_reg,
                                              4'h0, dir_write_reg, busy_reg}; // R7
                default:       host_rdata <= 32'h0000_0000;
            endcase
        end
        else
            host_rdata <= 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // crossing to and from the frame engine

    // a toggle asks for one frame; fields stay still while busy
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            start_tgl_reg <= 1'b0;
        else if (launch)
            start_tgl_reg <= ~start_tgl_reg;                 // R1
    end

    // completion toggle brought over by two flops plus an edge stage
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            done_sync_reg <= 3'h0;
        else
            done_sync_reg <= {done_sync_reg[1:0], u_if.done_tgl};
    end

    assign done_pulse = done_sync_reg[2] ^ done_sync_reg[1];

    assign u_if.start_tgl = start_tgl_reg;
    assign u_if.wr        = dir_write_reg;
    assign u_if.phy_sel   = phy_sel_reg;
    assign u_if.reg_idx   = reg_idx_reg;
    assign u_if.wdata     = data_reg;                        // R4

    pmx_frame_engine #(
        .LINK_KHZ (LINK_KHZ)
    ) u_eng (
        .mgmt_clk (mgmt_clk),
        .rst_b    (rst_b),
        .bus      (u_if.eng)
    );

    ////////////////////////////////////////////////////////////////////////
    // management path multiplexer

    // port 0 pin inputs pass two flops before the mux sees them
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            p0_mdc_sync_reg  <= 2'h0;
            p0_mdio_sync_reg <= 2'h3;
        end
        else
        begin
            p0_mdc_sync_reg  <= {p0_mdc_sync_reg[0], p0_mdc_i};
            p0_mdio_sync_reg <= {p0_mdio_sync_reg[0], p0_mdio_i};
        end
    end

    // reply levels of the internal PHYs and of the serial slave
    assign phy_rd = pmx_wired(phya_mdo, phya_mdo_oe_b)
                  & pmx_wired(phyb_mdo, phyb_mdo_oe_b);     // R14
    assign sms_rd = pmx_wired(sms_mdo, sms_mdo_oe_b);       // R14

    // the mode picks the master of the internal PHYs, the serial slave always follows port 0; replies are routed back
    always_comb
    begin
        sms_mdc      = p0_mdc_sync_reg[1];
        sms_mdio     = p0_mdio_sync_reg[1];
        u_if.mdi     = phy_rd;
        case (port0_mode)
            PMX_MAC_SMI:
            begin
                phy_mdc      = p0_mdc_sync_reg[1];           // R16
                phy_mdio     = p0_mdio_sync_reg[1];          // R16
                p0_mdio_o    = phy_rd & sms_rd;              // R14
                p0_mdio_oe_b = phya_mdo_oe_b & phyb_mdo_oe_b
                             & sms_mdo_oe_b;                 // R14
                u_if.mdi     = 1'b1;                         // R13
            end
            default:
            begin
                phy_mdc      = u_if.mdc;                     // R18
                phy_mdio     = pmx_wired(u_if.mdo, u_if.mdo_oe_b); // R18
                p0_mdio_o    = sms_rd;                       // R19
                p0_mdio_oe_b = sms_mdo_oe_b;                 // R19
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    sequence s_cmd_issue;
        launch ##1 busy_reg;
    endsequence

    a_busy_set: assert property (launch |-> s_cmd_issue)               // R6
        else $error("busy not set after command write");
    a_busy_hold: assert property (busy_reg && !done_pulse |=> busy_reg) // R6
        else $error("busy dropped without completion");
    a_busy_clear: assert property (done_pulse |=> !busy_reg)           // R7
        else $error("busy not cleared on completion");
    a_addr_load: assert property (launch |=>
        phy_sel_reg == $past(wr_data[`PMX_CMD_ADDR_HI:`PMX_CMD_ADDR_LO])) // R2
        else $error("target PHY not loaded");
    a_index_load: assert property (launch |=>
        reg_idx_reg == $past(wr_data[`PMX_CMD_IDX_HI:`PMX_CMD_IDX_LO])) // R3
        else $error("register index not loaded");
    a_read_store: assert property (done_pulse && !dir_write_reg |=>
        rd_result_reg == $past(u_if.rdata))                            // R5
        else $error("read data not stored");
    a_write_keep: assert property (busy_reg && dir_write_reg && !data_wr
        |=> $stable(data_reg))                                         // R22
        else $error("write data changed by engine");
    a_init_route: assert property (init_phase |-> phy_mdc == u_if.mdc // R18
        ##1 host_rdata == 32'h0000_0000)                               // R19
        else $error("internal PHYs not on engine in initialization");
    a_mac_route: assert property (port0_mode == PMX_MAC_SMI
        |-> phy_mdc == p0_mdc_sync_reg[1] && sms_mdc == phy_mdc)       // R16
        else $error("external master not routed");
endmodule

// *** rtl/pmx_pkg.sv ***
package pmx_pkg;
    // port 0 management path modes
    typedef enum logic [2:0] {
        PMX_MAC_SMI,
        PMX_MAC_SMI_INIT,
        PMX_PHY_SMI,
        PMX_PHY_SMI_INIT,
        PMX_MAC_I2C,
        PMX_PHY_I2C
    } pmx_mode_t;
    // frame engine states
    typedef enum logic {
        PMX_ENG_IDLE,
        PMX_ENG_RUN
    } pmx_eng_state_t;
    // level seen on a shared data line for one driver
    function automatic logic pmx_wired(input logic o, input logic oe_b);
        return oe_b ? 1'b1 : o;
    endfunction
endpackage

// *** rtl/pmx_regs.svh ***
`ifndef PMX_REGS_SVH
`define PMX_REGS_SVH
// register offsets
`define PMX_OFF_DATA    8'ha4
`define PMX_OFF_CMD     8'ha8
// command register fields
`define PMX_CMD_ADDR_HI 15
`define PMX_CMD_ADDR_LO 11
`define PMX_CMD_IDX_HI  10
`define PMX_CMD_IDX_LO  6
`define PMX_CMD_DIR     1
`define PMX_CMD_BUSY    0
// reset values
`define PMX_RST_ADDR    5'h00
`define PMX_RST_IDX     5'h00
`define PMX_RST_DATA    16'h0000
// management clock rate and frame layout
`define PMX_MDC_FREQ_KHZ 2500
`define PMX_LINK_KHZ     25000
`define PMX_FRAME_LAST   7'h3f
`define PMX_TA_BIT       7'h2e
`define PMX_DATA_BIT     7'h30
`endif

// *** sim/pmx_phy_model.sv ***
`timescale 1ns/100ps
module pmx_phy_model (
    input  wire logic        mdc,      // management clock from the engine
    input  wire logic        mdio,     // management data from the engine
    input  wire logic [15:0] rd_val,   // value returned on reads
    output logic             mdo,      // reply data, pulled high when released
    output logic             mdo_oe_b, // reply enable, low drives
    output logic [30:0]      frame,    // last frame after the first start bit
    output int               frames    // completed frame count
);
    logic [5:0] ones = 6'h00;
    logic [5:0] pos  = 6'h00;
    logic       act  = 1'b0;
    logic       rd   = 1'b0;
    initial frames = 0;
    initial frame = 31'h0;
    initial mdo = 1'b1;
    initial mdo_oe_b = 1'b1;
    ////////////////////////////////////////////////////////////////////////////////
    // preamble hunt, then shift in the frame on the sampling edge
    always @(posedge mdc)
    begin
        if (!act && mdio)
            ones <= (ones == 6'h20) ? ones : ones + 6'h01;
        else if (!act)
        begin
            act  <= (ones == 6'h20);
            ones <= 6'h00;
            pos  <= 6'h01;
        end
        else
        begin
            frame <= {frame[29:0], mdio};
            pos   <= pos + 6'h01;
            if (pos == 6'h03)
                rd <= ({frame[0], mdio} == 2'b10);
            if (pos == 6'h1f)
            begin
                act    <= 1'b0;
                frames <= frames + 1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // read reply: zero in the second turnaround bit, then data msb first
    always @(negedge mdc)
    begin
        mdo_oe_b <= !(act && rd && pos >= 6'h0f);
        if (act && rd && pos >= 6'h0f)
            mdo <= (pos == 6'h0f) ? 1'b0 : rd_val[4'(6'h1f - pos)];
        else
            mdo <= 1'b1;
    end
endmodule

// *** sim/tb.sv ***
`timescale 1ns/100ps
module tb;
    import pmx_pkg::*;
    logic        clock = 1'b0;
    logic        mgmt_clk = 1'b0;
    logic        rst_b = 1'b0;
    pmx_mode_t   port0_mode = PMX_PHY_SMI;
    logic        host_wr_en = 1'b0;
    logic        host_rd_en = 1'b0;
    logic [7:0]  host_addr = 8'h00;
    logic [31:0] host_wdata = 32'h0;
    logic [31:0] host_rdata;
    logic        ee_wr_en = 1'b0;
    logic [7:0]  ee_addr = 8'h00;
    logic [31:0] ee_wdata = 32'h0;
    logic        cmd_busy;
    logic        p0_mdc_i = 1'b0;
    logic        p0_mdio_i = 1'b1;
    logic        phy_mdc;
    logic        phy_mdio;
    logic        phya_mdo;
    logic        phya_mdo_oe_b;
    logic        sms_mdc;
    logic        sms_mdio;
    logic        sms_mdo = 1'b0;
    logic        sms_mdo_oe_b = 1'b1;
    logic        p0_mdio_o;
    logic        p0_mdio_oe_b;
    logic [15:0] phy_val = 16'h0;
    logic [30:0] frame;
    int          frames;
    int          failures = 0;
    int          checked = 0;
    int          cyc = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // clocks: system 40 ns, link 15 ns with an unrelated phase
    initial forever #20 clock = ~clock;
    initial
    begin
        #3.3;
        forever #7.5 mgmt_clk = ~mgmt_clk;
    end
    pmx_phy_mgmt_mux #(.LINK_KHZ(66667)) dut (
        .clock(clock), .rst_b(rst_b), .mgmt_clk(mgmt_clk), .port0_mode(port0_mode),
        .host_wr_en(host_wr_en), .host_rd_en(host_rd_en), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .ee_wr_en(ee_wr_en),
        .ee_addr(ee_addr), .ee_wdata(ee_wdata), .cmd_busy(cmd_busy),
        .p0_mdc_i(p0_mdc_i), .p0_mdio_i(p0_mdio_i), .p0_mdio_o(p0_mdio_o),
        .p0_mdio_oe_b(p0_mdio_oe_b),
        .phy_mdc(phy_mdc), .phy_mdio(phy_mdio), .phya_mdo(phya_mdo),
        .phya_mdo_oe_b(phya_mdo_oe_b), .phyb_mdo(1'b1), .phyb_mdo_oe_b(1'b1),
        .sms_mdc(sms_mdc), .sms_mdio(sms_mdio), .sms_mdo(sms_mdo),
        .sms_mdo_oe_b(sms_mdo_oe_b));
    pmx_phy_model model (.mdc(phy_mdc), .mdio(phy_mdio), .rd_val(phy_val), .mdo(phya_mdo),
        .mdo_oe_b(phya_mdo_oe_b), .frame(frame), .frames(frames));
    ////////////////////////////////////////////////////////////////////////////////
    // closing report and hang guard
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            failures++;
            report_and_stop;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // register bus tasks and value compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic ee, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        if (ee)
        begin
            ee_wr_en <= 1'b1;
            ee_addr  <= a;
            ee_wdata <= d;
        end
        else
        begin
            host_wr_en <= 1'b1;
            host_addr  <= a;
            host_wdata <= d;
        end
        @(posedge clock);
        ee_wr_en   <= 1'b0;
        host_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        host_rd_en <= 1'b1;
        host_addr  <= a;
        @(posedge clock);
        host_rd_en <= 1'b0;
        #1 d = host_rdata;
    endtask
    function automatic logic [31:0] cmd_word(input logic [4:0] a, input logic [4:0] i,
                                             input logic dir);
        return {16'h0, a, i, 4'h0, dir, 1'b0};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // one full transfer: optional data write, command, busy poll, result checks
    task automatic xfer(input logic ee, input logic dir, input logic [4:0] a,
                        input logic [4:0] i, input logic [15:0] v);
        logic [31:0] got;
        int          n;
        n       = frames;
        phy_val = v;
        if (dir)
            wr(ee, 8'ha4, {16'h0, v});
        wr(ee, 8'ha8, cmd_word(a, i, dir));
        #1 chk(32'(cmd_busy), 32'h1);
        if (!ee)
        begin
            wr(1'b0, 8'ha8, cmd_word(~a, ~i, dir));
            rd(8'ha8, got);
            chk(got, cmd_word(a, i, dir) | 32'h1);
            rd(8'ha4, got);
            if (dir)
                chk(got, {16'h0, v});
        end
        for (int k = 0; k < 3000 && cmd_busy !== 1'b0; k++)
            @(posedge clock) #1;
        chk(32'(frames - n), 32'h1);
        if (dir)
            chk({1'b0, frame}, {1'b0, 1'b1, 2'b01, a, i, 2'b10, v});
        else
            chk({19'h0, frame[30:18]}, {19'h0, 1'b1, 2'b10, a, i});
        if (!ee && !dir)
        begin
            rd(8'ha4, got);
            chk(got, {16'h0, v});
            wr(1'b0, 8'ha4, {16'h0, ~v});
            rd(8'ha4, got);
            chk(got, {16'h0, v});
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        logic [31:0] got;
        void'($urandom(43858));
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        rd(8'ha8, got);
        chk(got, 32'h0);
        rd(8'ha4, got);
        chk(got, 32'h0);
        rd(8'h10, got);
        chk(got, 32'h0);
        repeat (4)
            xfer(1'b0, 1'($urandom), 5'($urandom), 5'($urandom), 16'($urandom));
        xfer(1'b0, 1'b1, 5'h1f, 5'h1f, 16'hffff);
        xfer(1'b0, 1'b0, 5'h00, 5'h1f, 16'h8001);
        // the init and i2c modes route the loader's frames to the phys
        for (int m = 1; m < 6; m++)
        begin
            if (m == 2)
                continue;
            @(posedge clock);
            port0_mode <= pmx_mode_t'(m);
            xfer(1'b1, 1'b1, 5'($urandom), 5'($urandom), 16'($urandom));
        end
        // host is shut out during initialization
        @(posedge clock);
        port0_mode <= PMX_MAC_SMI_INIT;
        rd(8'ha8, got);
        chk(got, 32'h0);
        wr(1'b0, 8'ha8, cmd_word(5'h01, 5'h01, 1'b1));
        #1 chk(32'(cmd_busy), 32'h0);
        // plain mac mode: external pins reach the phys and the serial slave
        @(posedge clock);
        port0_mode <= PMX_MAC_SMI;
        for (int b = 1; b >= 0; b--)
        begin
            @(posedge clock);
            p0_mdc_i     <= 1'(b);
            p0_mdio_i    <= 1'(b);
            sms_mdo_oe_b <= 1'(b);
            repeat (4) @(posedge clock);
            #1 chk({28'h0, phy_mdc, phy_mdio, sms_mdc, sms_mdio}, {28'h0, {4{1'(b)}}});
            chk({30'h0, p0_mdio_o, p0_mdio_oe_b}, {30'h0, {2{1'(b)}}});
        end
        report_and_stop;
    end
endmodule
